/* File: hw/nfcirq_pkg.sv */
// Package with register map and field layout of the interrupt flag block
package nfcirq_pkg;
  // Register indices (printed offsets are not all multiples of four: byte address is index times four)
  localparam logic [7:0] NFCIRQ_IDX_MASK_MAIN = 8'h16;
  localparam logic [7:0] NFCIRQ_IDX_MASK_TIMER = 8'h17;
  localparam logic [7:0] NFCIRQ_IDX_MASK_ERROR = 8'h18;
  localparam logic [7:0] NFCIRQ_IDX_MAIN = 8'h1A;
  localparam logic [7:0] NFCIRQ_IDX_TIMER = 8'h1B;
  localparam logic [7:0] NFCIRQ_IDX_ERROR = 8'h1C;
  localparam int NFCIRQ_ADDR_W = 10;
  // Main register bit positions
  localparam int NFCIRQ_MAIN_OSC = 7;
  localparam int NFCIRQ_MAIN_FIFO_LEVEL = 6;
  localparam int NFCIRQ_MAIN_RX_START = 5;
  localparam int NFCIRQ_MAIN_RX_END = 4;
  localparam int NFCIRQ_MAIN_TX_END = 3;
  localparam int NFCIRQ_MAIN_COLLISION = 2;
  localparam int NFCIRQ_MAIN_RX_RESTART = 1;
  localparam logic [7:0] NFCIRQ_MAIN_USED = 8'hFE;
  // FIFO level thresholds in bytes
  localparam logic [9:0] NFCIRQ_RX_LEVEL = 10'd300;
  localparam logic [9:0] NFCIRQ_TX_LEVEL = 10'd200;
  // Reset values
  localparam logic [7:0] NFCIRQ_FLAGS_RST = 8'h00;
  localparam logic [7:0] NFCIRQ_MASK_RST = 8'h00;
endpackage

/* File: hw/nfcirq_top.sv */
// Interrupt flag registers with masks and request output, Avalon-MM slave
`timescale 1ns/1ps
module nfcirq_top
  import nfcirq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [nfcirq_pkg::NFCIRQ_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Event strobes, one cycle each
  input wire logic osc_stable,
  input wire logic rx_start,
  input wire logic rx_end,
  input wire logic tx_end,
  input wire logic bit_collision,
  input wire logic disturbance_frame,
  input wire logic cmd_done,
  input wire logic noresp_timeout,
  input wire logic gp_timeout,
  input wire logic field_on,
  input wire logic field_off,
  input wire logic ca_collision,
  input wire logic ca_guard_done,
  input wire logic target_rate_found,
  input wire logic crc_error,
  input wire logic parity_error,
  input wire logic soft_framing_irq,
  input wire logic hard_framing_irq,
  input wire logic wakeup_timer_irq,
  input wire logic amp_over_ref,
  input wire logic phase_over_ref,
  input wire logic cap_over_ref,
  // FIFO state levels
  input wire logic receiving,
  input wire logic transmitting,
  input wire logic [9:0] fifo_count,
  // Interrupt request
  output logic irq
);
  import nfcirq_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [7:0] main_q;
  logic [7:0] timer_q;
  logic [7:0] error_q;
  logic [7:0] mask_main_q;
  logic [7:0] mask_timer_q;
  logic [7:0] mask_error_q;
  logic ack_q;
  logic [7:0] fifo_level_q;
  logic rd_done;
  logic wr_done;
  logic [7:0] index;

  function automatic logic hit(input logic [nfcirq_pkg::NFCIRQ_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[NFCIRQ_ADDR_W-1:2] == idx);
  endfunction

  // One wait state: request is acted on at the edge where waitrequest is low
  assign rd_done = avs_read && ack_q;
  assign wr_done = avs_write && ack_q && avs_byteenable[0];
  assign index = avs_address[NFCIRQ_ADDR_W-1:2];

  always_ff @(posedge clk)
  begin
    if (rst || ack_q)
      ack_q <= 1'b0;
    else
      ack_q <= avs_read || avs_write;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end
    else if (avs_read && !ack_q)
    begin
      avs_response <= 2'b00;
      avs_readdata <= 32'h0000_0000;
      if (hit(avs_address, NFCIRQ_IDX_MAIN))
        avs_readdata[7:0] <= main_q & NFCIRQ_MAIN_USED;
      else if (hit(avs_address, NFCIRQ_IDX_TIMER))
        avs_readdata[7:0] <= timer_q;
      else if (hit(avs_address, NFCIRQ_IDX_ERROR))
        avs_readdata[7:0] <= error_q;
      else if (hit(avs_address, NFCIRQ_IDX_MASK_MAIN))
        avs_readdata[7:0] <= mask_main_q;
      else if (hit(avs_address, NFCIRQ_IDX_MASK_TIMER))
        avs_readdata[7:0] <= mask_timer_q;
      else if (hit(avs_address, NFCIRQ_IDX_MASK_ERROR))
        avs_readdata[7:0] <= mask_error_q;
      else
        avs_response <= 2'b10;
    end
  end

  // ----------------------------------------
  // Mask registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask_main_q <= NFCIRQ_MASK_RST;
      mask_timer_q <= NFCIRQ_MASK_RST;
      mask_error_q <= NFCIRQ_MASK_RST;
    end
    else if (wr_done)
    begin
      if (hit(avs_address, NFCIRQ_IDX_MASK_MAIN))
        mask_main_q <= avs_writedata[7:0] & NFCIRQ_MAIN_USED;
      if (hit(avs_address, NFCIRQ_IDX_MASK_TIMER))
        mask_timer_q <= avs_writedata[7:0];
      if (hit(avs_address, NFCIRQ_IDX_MASK_ERROR))
        mask_error_q <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------
  // Event vectors
  // ----------------------------------------
  logic [7:0] main_ev;
  logic [7:0] timer_ev;
  logic [7:0] error_ev;
  logic level_hit;
  logic level_rise;

  // Level condition is edge-detected so a standing level does not refill the flag after a read
  assign level_hit = (receiving && (fifo_count > NFCIRQ_RX_LEVEL)) ||
                     (transmitting && (fifo_count < NFCIRQ_TX_LEVEL));
  assign level_rise = level_hit && !fifo_level_q[0];

  always_ff @(posedge clk)
  begin
    if (rst)
      fifo_level_q <= 8'h00;
    else
      fifo_level_q <= {7'h00, level_hit};
  end

  always_comb
  begin
    main_ev = 8'h00;
    main_ev[NFCIRQ_MAIN_OSC] = osc_stable;
    main_ev[NFCIRQ_MAIN_FIFO_LEVEL] = level_rise;
    main_ev[NFCIRQ_MAIN_RX_START] = rx_start;
    main_ev[NFCIRQ_MAIN_RX_END] = rx_end;
    main_ev[NFCIRQ_MAIN_TX_END] = tx_end;
    main_ev[NFCIRQ_MAIN_COLLISION] = bit_collision;
    main_ev[NFCIRQ_MAIN_RX_RESTART] = disturbance_frame;
  end

  assign timer_ev = {cmd_done, noresp_timeout, gp_timeout,
                     field_on, field_off,
                     ca_collision,
                     ca_guard_done,
                     target_rate_found};

  assign error_ev = {crc_error, parity_error,
                     soft_framing_irq,
                     hard_framing_irq,
                     wakeup_timer_irq,
                     amp_over_ref,
                     phase_over_ref,
                     cap_over_ref};

  // ----------------------------------------
  // Flag registers, clear on read, set wins over clear
  // ----------------------------------------
  logic main_rd;
  logic timer_rd;
  logic error_rd;

  assign main_rd = rd_done && hit(avs_address, NFCIRQ_IDX_MAIN);
  assign timer_rd = rd_done && hit(avs_address, NFCIRQ_IDX_TIMER);
  assign error_rd = rd_done && hit(avs_address, NFCIRQ_IDX_ERROR);

  // Main register is also cleared on read so its request can drop
  always_ff @(posedge clk)
  begin
    if (rst)
      main_q <= NFCIRQ_FLAGS_RST;
    else
      main_q <= ((main_rd ? 8'h00 : main_q) | main_ev) & NFCIRQ_MAIN_USED;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      timer_q <= NFCIRQ_FLAGS_RST;
    else
      timer_q <= (timer_rd ? 8'h00 : timer_q) | timer_ev;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      error_q <= NFCIRQ_FLAGS_RST;
    else
      error_q <= (error_rd ? 8'h00 : error_q) | error_ev;
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  logic irq_d;

  // Computed from next flag values so irq stays a pure flip-flop yet tracks flags exactly
  always_comb
  begin
    irq_d = |((((main_rd ? 8'h00 : main_q) | main_ev) & NFCIRQ_MAIN_USED & ~mask_main_q) |
              (((timer_rd ? 8'h00 : timer_q) | timer_ev) & ~mask_timer_q) |
              (((error_rd ? 8'h00 : error_q) | error_ev) & ~mask_error_q));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= irq_d;
  end

  logic unused_ok;
  assign unused_ok = ^{avs_byteenable[3:1], avs_writedata[31:8], index, fifo_level_q[7:1]};
endmodule

/* File: testbench/nfcirq_sva.sv */
// Bus timing and flag assertions for the interrupt flag block
`timescale 1ns/1ps
module nfcirq_sva
  import nfcirq_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic [nfcirq_pkg::NFCIRQ_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Request
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic mapped;
  assign mapped = avs_address[1:0] == 2'h0 && avs_address[9:2] inside {8'h16, 8'h17, 8'h18, 8'h1A, 8'h1B, 8'h1C};
  sequence s_rd_done; avs_read && !avs_waitrequest; endsequence
  property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
  property p_err; s_rd_done ##0 !mapped |-> avs_response == 2'h2 && avs_readdata == 32'h0; endproperty
  property p_ok; s_rd_done ##0 mapped |-> avs_response == 2'h0; endproperty
  property p_high; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  property p_rfu; s_rd_done ##0 avs_address == {NFCIRQ_IDX_MAIN, 2'h0} |-> !avs_readdata[0]; endproperty
  property p_fall; $fell(irq) |-> $past(!avs_waitrequest) || $past(!avs_waitrequest, 2); endproperty
  a_take: assert property (p_take) else $error("request not answered next cycle");
  a_one: assert property (p_one) else $error("waitrequest low too long");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_err: assert property (p_err) else $error("unmapped read not refused");
  a_ok: assert property (p_ok) else $error("mapped read gave error");
  a_high: assert property (p_high) else $error("upper read bits not zero");
  a_rfu: assert property (p_rfu) else $error("main bit 0 not zero");
  a_fall: assert property (p_fall) else $error("irq dropped without access");
endmodule
bind nfcirq_top nfcirq_sva u_sva (.*);

/* File: testbench/nfcirq_host.sv */
// Host master model on the Avalon-MM register bus
`timescale 1ns/1ps
module nfcirq_host
  import nfcirq_pkg::*;
(
  // Bus
  input wire logic clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  output logic [nfcirq_pkg::NFCIRQ_ADDR_W-1:0] avs_address = '0,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [3:0] avs_byteenable = 4'hF,
  output logic [31:0] avs_writedata = '0
);
  import nfcirq_pkg::*;
  // ----
  // Transfer; drives one read or write and waits for waitrequest low
  // ----
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, wd};
    avs_write <= we;
    avs_read <= !we;
    // No cycle limit here: only the bench watchdog ends a hung wait
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines must not keep the old value
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule

/* File: testbench/test_nfcirq_top.sv */
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module test_nfcirq_top;
  import nfcirq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] ev = '0;
  logic receiving = 1'b0;
  logic transmitting = 1'b0;
  logic [9:0] fifo_count = '0;
  logic [9:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] avs_response, rs;
  int fails = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  nfcirq_host u_host (.*);
  nfcirq_top u_dut (.*, .osc_stable(ev[23]), .rx_start(ev[21]), .rx_end(ev[20]), .tx_end(ev[19]),
    .bit_collision(ev[18]), .disturbance_frame(ev[17]), .cmd_done(ev[15]), .noresp_timeout(ev[14]),
    .gp_timeout(ev[13]), .field_on(ev[12]), .field_off(ev[11]), .ca_collision(ev[10]), .ca_guard_done(ev[9]),
    .target_rate_found(ev[8]), .crc_error(ev[7]), .parity_error(ev[6]), .soft_framing_irq(ev[5]),
    .hard_framing_irq(ev[4]), .wakeup_timer_irq(ev[3]), .amp_over_ref(ev[2]), .phase_over_ref(ev[1]),
    .cap_over_ref(ev[0]));
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    u_host.xfer(1'b0, idx, 8'h00, rd, rs);
    check("readdata", rd, {24'h0, exp});
    check("response", {30'h0, rs}, 32'h0);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #50000;
    fails++;
    give_verdict();
  end
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int j = 0; j < 7; j++)
      if (j != 3)
        rd_chk(8'(8'h16 + j), 8'h00);
    u_host.xfer(1'b0, 8'h19, 8'h00, rd, rs);
    check("unmapped response", {30'h0, rs}, 32'h2);
    check("unmapped readdata", rd, 32'h0);
    // Main bit 6 has no strobe, main bit 0 is reserved
    for (int i = 0; i < 24; i++)
    begin
      if (i == 16 || i == 22)
        continue;
      pulse(i);
      check("irq", {31'h0, irq}, 32'h1);
      rd_chk(8'(8'h1C - i / 8), 8'(1 << (i % 8)));
      rd_chk(8'(8'h1C - i / 8), 8'h00);
      #1;
      check("irq", {31'h0, irq}, 32'h0);
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      receiving <= k < 2;
      transmitting <= k >= 2;
      fifo_count <= k < 2 ? 10'(10'h12C + k) : 10'(10'h0CA - k);
      repeat (2) @(posedge clk);
      receiving <= 1'b0;
      transmitting <= 1'b0;
      rd_chk(NFCIRQ_IDX_MAIN, k[0] ? 8'h40 : 8'h00);
    end
    u_host.xfer(1'b1, NFCIRQ_IDX_MASK_ERROR, 8'h80, rd, rs);
    rd_chk(NFCIRQ_IDX_MASK_ERROR, 8'h80);
    pulse(7);
    check("masked irq", {31'h0, irq}, 32'h0);
    pulse(6);
    check("irq", {31'h0, irq}, 32'h1);
    rd_chk(NFCIRQ_IDX_ERROR, 8'hC0);
    give_verdict();
  end
endmodule
